// ===== core/snw_top.sv
`timescale 1ns/1ps
`default_nettype none
module snw_top (
   input wire logic core_clk_in, // Bus clock, 20 MHz.
   input wire logic nrst_in, // Asynchronous reset, active low.
   input wire logic [snw_pkg::SNW_ADDR_W-1:0] s_axi_awaddr_in, // Write address.
   input wire logic s_axi_awvalid_in, // Write address valid.
   output logic s_axi_awready_out, // Write address ready.
   input wire logic [snw_pkg::SNW_DATA_W-1:0] s_axi_wdata_in, // Write data.
   input wire logic [3:0] s_axi_wstrb_in, // Write strobes.
   input wire logic s_axi_wvalid_in, // Write data valid.
   output logic s_axi_wready_out, // Write data ready.
   output logic [1:0] s_axi_bresp_out, // Write response.
   output logic s_axi_bvalid_out, // Write response valid.
   input wire logic s_axi_bready_in, // Write response ready.
   input wire logic [snw_pkg::SNW_ADDR_W-1:0] s_axi_araddr_in, // Read address.
   input wire logic s_axi_arvalid_in, // Read address valid.
   output logic s_axi_arready_out, // Read address ready.
   output logic [snw_pkg::SNW_DATA_W-1:0] s_axi_rdata_out, // Read data.
   output logic [1:0] s_axi_rresp_out, // Read response.
   output logic s_axi_rvalid_out, // Read data valid.
   input wire logic s_axi_rready_in, // Read data ready.
   input wire logic char9_mode_in, // 9-bit character mode selected.
   input wire logic loop_mode_select_in, // Loop mode select.
   input wire logic receiver_source_select_in, // Receiver source select.
   input wire logic data_wr_in, // Data register write pulse.
   input wire logic [7:0] data_wr_byte_in, // Byte written to data register.
   input wire logic rx_char_done_in, // Received character pulse.
   input wire logic rx_ninth_in, // Ninth bit of that character.
   output logic tx_shift_load_out, // Shift register load pulse.
   output logic [8:0] tx_shift_word_out, // Word for the shift register.
   output logic tx_shift_nine_out, // Loaded word has nine bits.
   output logic single_wire_out, // Single-wire half-duplex active.
   output logic txd_oe_n_out // Transmit pin output enable, low drives.
);
   import snw_pkg::*;

   snw_core_state_t c_reg;
   snw_core_state_t c_next;
   logic wr_fire;
   logic [SNW_ADDR_W-1:0] wr_addr;
   logic [SNW_DATA_W-1:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic rd_fire;
   logic [SNW_DATA_W-1:0] rd_data;
   logic rd_err;
   logic ctl_wr;
   logic sw_mode;

   //////////////////////////////////////////////////////////////////////////
   // Bus slave.
   snw_axil_slave u_axil (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .awaddr_in(s_axi_awaddr_in),
      .awvalid_in(s_axi_awvalid_in),
      .awready_out(s_axi_awready_out),
      .wdata_in(s_axi_wdata_in),
      .wstrb_in(s_axi_wstrb_in),
      .wvalid_in(s_axi_wvalid_in),
      .wready_out(s_axi_wready_out),
      .bresp_out(s_axi_bresp_out),
      .bvalid_out(s_axi_bvalid_out),
      .bready_in(s_axi_bready_in),
      .araddr_in(s_axi_araddr_in),
      .arvalid_in(s_axi_arvalid_in),
      .arready_out(s_axi_arready_out),
      .rdata_out(s_axi_rdata_out),
      .rresp_out(s_axi_rresp_out),
      .rvalid_out(s_axi_rvalid_out),
      .rready_in(s_axi_rready_in),
      .wr_fire_out(wr_fire),
      .wr_addr_out(wr_addr),
      .wr_data_out(wr_data),
      .wr_strb_out(wr_strb),
      .wr_err_in(wr_err),
      .rd_fire_out(rd_fire),
      .rd_data_in(rd_data),
      .rd_err_in(rd_err)
   );

   //////////////////////////////////////////////////////////////////////////
   // Address decode; only the third control register is mapped.
   assign wr_err = (wr_addr != SNW_CTL3_OFFSET);
   assign rd_err = (s_axi_araddr_in != SNW_CTL3_OFFSET);
   assign ctl_wr = wr_fire && !wr_err && wr_strb[0];
   assign sw_mode = loop_mode_select_in && receiver_source_select_in; // R6

   // Read view of the register; bits 4 to 0 and upper lanes read zero.
   always_comb begin
      rd_data = '0;
      if (rd_fire && !rd_err) begin
         rd_data[SNW_RX_NINTH_POS] = c_reg.rx_ninth; // R1
         rd_data[SNW_TX_NINTH_POS] = c_reg.tx_ninth;
         rd_data[SNW_PIN_DIR_POS] = c_reg.pin_dir;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state of the core.
   always_comb begin
      c_next = c_reg;
      // Software fields; the received ninth bit is read only.
      if (ctl_wr) begin
         c_next.tx_ninth = wr_data[SNW_TX_NINTH_POS];
         c_next.pin_dir = wr_data[SNW_PIN_DIR_POS];
      end
      // Received ninth bit follows each character in 9-bit mode only.
      if (rx_char_done_in && char9_mode_in) begin // R8
         c_next.rx_ninth = rx_ninth_in; // R1
      end
      // A data write moves the byte, plus the held ninth bit in 9-bit mode only.
      c_next.tx_load = data_wr_in; // R3
      if (data_wr_in) begin
         c_next.tx_word = {char9_mode_in & c_reg.tx_ninth, // R5 R8
                           data_wr_byte_in}; // R3
         c_next.tx_nine = char9_mode_in;
      end
      // Direction bit acts only in single-wire mode; elsewhere pin drives.
      c_next.single_wire = sw_mode; // R6
      c_next.txd_oe_n = sw_mode ? !c_reg.pin_dir : 1'b0; // R7
   end

   // Core state register.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         c_reg <= '{tx_ninth: SNW_TX_NINTH_RST, pin_dir: SNW_PIN_DIR_RST,
                    rx_ninth: SNW_RX_NINTH_RST, default: '0};
      end else begin
         c_reg <= c_next;
      end
   end

   // Link-side outputs straight from flops.
   assign tx_shift_load_out = c_reg.tx_load;
   assign tx_shift_word_out = c_reg.tx_word;
   assign tx_shift_nine_out = c_reg.tx_nine;
   assign single_wire_out = c_reg.single_wire;
   assign txd_oe_n_out = c_reg.txd_oe_n;

   //////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_data_write_keep;
      data_wr_in && !ctl_wr && char9_mode_in;
   endsequence

   sequence s_second_write;
      data_wr_in && !ctl_wr && char9_mode_in;
   endsequence

   a_rx_ninth_capture: assert property ( // R1
      rx_char_done_in && char9_mode_in |=> c_reg.rx_ninth == $past(rx_ninth_in))
      else $error("Received ninth bit not captured in 9-bit mode.");

   a_rx_ninth_frozen: assert property ( // R8
      !(rx_char_done_in && char9_mode_in) |=> $stable(c_reg.rx_ninth))
      else $error("Received ninth bit changed outside 9-bit capture.");

   a_tx_word_load: assert property ( // R3
      data_wr_in && char9_mode_in |=> tx_shift_load_out
         && tx_shift_word_out == {$past(c_reg.tx_ninth), $past(data_wr_byte_in)})
      else $error("Shift register load does not carry ninth bit and byte.");

   a_tx_eight_bit: assert property ( // R8
      data_wr_in && !char9_mode_in |=> tx_shift_load_out
         && !tx_shift_word_out[8] && !tx_shift_nine_out)
      else $error("Ninth bit leaked into an 8-bit character.");

   a_tx_ninth_reuse: assert property ( // R5
      s_data_write_keep ##1 (!ctl_wr [*1]) ##1 s_second_write
         |=> tx_shift_word_out[8] == $past(tx_shift_word_out[8], 2))
      else $error("Ninth bit not reused across data writes.");

   a_single_wire_mode: assert property ( // R6
      !sw_mode |=> !single_wire_out && !txd_oe_n_out)
      else $error("Direction bit acted outside single-wire mode.");

   a_pin_direction: assert property ( // R7
      sw_mode |=> single_wire_out && txd_oe_n_out == !$past(c_reg.pin_dir))
      else $error("Transmit pin direction does not follow bit 5.");

   a_no_load_idle: assert property ( // R3
      !data_wr_in |=> !tx_shift_load_out)
      else $error("Shift register loaded without a data write.");

   // A register read returns the fields held before the address was taken.
   a_read_view: assert property ( // R1
      rd_fire && !rd_err |=> s_axi_rvalid_out
         && s_axi_rdata_out == {24'h0, $past(c_reg.rx_ninth),
         $past(c_reg.tx_ninth), $past(c_reg.pin_dir), 5'h0})
      else $error("Register read does not show the held fields.");

   a_dir_write: assert property ( // R7
      ctl_wr |=> c_reg.pin_dir == $past(wr_data[SNW_PIN_DIR_POS]))
      else $error("Direction bit not taken from a register write.");

   a_tx_ninth_write: assert property ( // R3
      ctl_wr |=> c_reg.tx_ninth == $past(wr_data[SNW_TX_NINTH_POS]))
      else $error("Transmit ninth bit not taken from a register write.");

   a_tx_ninth_hold: assert property ( // R5
      !ctl_wr |=> $stable(c_reg.tx_ninth) && $stable(c_reg.pin_dir))
      else $error("Held control bit changed without a register write.");

   a_tx_word_hold: assert property ( // R3
      !data_wr_in |=> $stable(tx_shift_word_out)
         && $stable(tx_shift_nine_out))
      else $error("Shift register word changed without a data write.");

   a_nine_flag: assert property ( // R8
      data_wr_in |=> tx_shift_nine_out == $past(char9_mode_in))
      else $error("Character size flag does not follow the mode select.");

endmodule : snw_top
`default_nettype wire

// ===== core/snw_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// R1 - In 9-bit mode the received ninth bit is shown in bit 7 of the third control register.
// R2 - Software reads the received ninth bit before the data register, since that read may let a new character overwrite both.
// R3 - In 9-bit mode a data register write loads the transmit ninth bit (bit 6) plus the data byte into the shift register.
// R4 - Software updates the transmit ninth bit before writing the data register when it must change.
// R5 - The transmit ninth bit is held across data writes, so a fixed parity value need not be rewritten.
// R6 - Single-wire half-duplex is active only when loop mode and receiver source are both 1, and only then does the direction bit act.
// R7 - In single-wire mode bit 5 sets the transmit pin direction: 0 input, 1 driven output.
// R8 - In 8-bit mode the transmit ninth bit is not sent and the received ninth bit is not updated.
//////////////////////////////////////////////////////////////////////////////
package snw_pkg;

   // Bus geometry.
   localparam int SNW_ADDR_W = 8;
   localparam int SNW_DATA_W = 32;

   // Register offset of the third control register.
   localparam logic [SNW_ADDR_W-1:0] SNW_CTL3_OFFSET = 8'h00;

   // Field positions inside the third control register.
   localparam int SNW_RX_NINTH_POS = 7;
   localparam int SNW_TX_NINTH_POS = 6;
   localparam int SNW_PIN_DIR_POS = 5;

   // Reset values of the fields.
   localparam logic SNW_RX_NINTH_RST = 1'b0;
   localparam logic SNW_TX_NINTH_RST = 1'b0;
   localparam logic SNW_PIN_DIR_RST = 1'b0;

   // Bus response codes.
   localparam logic [1:0] SNW_RESP_OKAY = 2'h0;
   localparam logic [1:0] SNW_RESP_SLVERR = 2'h2;

   // State of the bus slave.
   typedef struct packed {
      logic aw_rdy;
      logic aw_full;
      logic [SNW_ADDR_W-1:0] awaddr;
      logic w_rdy;
      logic w_full;
      logic [SNW_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [SNW_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } snw_axil_state_t;

   // State of the ninth bit and wire direction core.
   typedef struct packed {
      logic tx_ninth;
      logic pin_dir;
      logic rx_ninth;
      logic tx_load;
      logic [8:0] tx_word;
      logic tx_nine;
      logic single_wire;
      logic txd_oe_n;
   } snw_core_state_t;

endpackage : snw_pkg

// ===== core/snw_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module snw_axil_slave (
   input wire logic core_clk_in, // Bus clock.
   input wire logic nrst_in, // Asynchronous reset, active low.
   input wire logic [snw_pkg::SNW_ADDR_W-1:0] awaddr_in, // Write address.
   input wire logic awvalid_in, // Write address valid.
   output logic awready_out, // Write address ready.
   input wire logic [snw_pkg::SNW_DATA_W-1:0] wdata_in, // Write data.
   input wire logic [3:0] wstrb_in, // Write byte strobes.
   input wire logic wvalid_in, // Write data valid.
   output logic wready_out, // Write data ready.
   output logic [1:0] bresp_out, // Write response.
   output logic bvalid_out, // Write response valid.
   input wire logic bready_in, // Write response ready.
   input wire logic [snw_pkg::SNW_ADDR_W-1:0] araddr_in, // Read address.
   input wire logic arvalid_in, // Read address valid.
   output logic arready_out, // Read address ready.
   output logic [snw_pkg::SNW_DATA_W-1:0] rdata_out, // Read data.
   output logic [1:0] rresp_out, // Read response.
   output logic rvalid_out, // Read data valid.
   input wire logic rready_in, // Read data ready.
   output logic wr_fire_out, // Register write strobe.
   output logic [snw_pkg::SNW_ADDR_W-1:0] wr_addr_out, // Register write address.
   output logic [snw_pkg::SNW_DATA_W-1:0] wr_data_out, // Register write data.
   output logic [3:0] wr_strb_out, // Register write strobes.
   input wire logic wr_err_in, // Write address unmapped.
   output logic rd_fire_out, // Register read strobe.
   input wire logic [snw_pkg::SNW_DATA_W-1:0] rd_data_in, // Read value.
   input wire logic rd_err_in // Read address unmapped.
);
   import snw_pkg::*;

   snw_axil_state_t s_reg;
   snw_axil_state_t s_next;

   // Address and data are held independently, then the write fires once.
   always_comb begin
      s_next = s_reg;
      wr_fire_out = 1'b0;
      rd_fire_out = 1'b0;
      if (s_reg.aw_rdy && awvalid_in) begin
         s_next.aw_full = 1'b1;
         s_next.aw_rdy = 1'b0;
         s_next.awaddr = awaddr_in;
      end
      if (s_reg.w_rdy && wvalid_in) begin
         s_next.w_full = 1'b1;
         s_next.w_rdy = 1'b0;
         s_next.wdata = wdata_in;
         s_next.wstrb = wstrb_in;
      end
      if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
         wr_fire_out = 1'b1;
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = wr_err_in ? SNW_RESP_SLVERR : SNW_RESP_OKAY;
      end
      if (s_reg.bvalid && bready_in) begin
         s_next.bvalid = 1'b0;
         s_next.aw_rdy = 1'b1;
         s_next.w_rdy = 1'b1;
      end
      // A read is decoded in the cycle its address is taken.
      if (s_reg.ar_rdy && arvalid_in) begin
         rd_fire_out = 1'b1;
         s_next.ar_rdy = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_data_in;
         s_next.rresp = rd_err_in ? SNW_RESP_SLVERR : SNW_RESP_OKAY;
      end
      if (s_reg.rvalid && rready_in) begin
         s_next.rvalid = 1'b0;
         s_next.ar_rdy = 1'b1;
      end
   end

   // State register; all channels ready after reset.
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_reg <= '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Bus outputs come straight from the state register.
   assign awready_out = s_reg.aw_rdy;
   assign wready_out = s_reg.w_rdy;
   assign bvalid_out = s_reg.bvalid;
   assign bresp_out = s_reg.bresp;
   assign arready_out = s_reg.ar_rdy;
   assign rvalid_out = s_reg.rvalid;
   assign rdata_out = s_reg.rdata;
   assign rresp_out = s_reg.rresp;
   assign wr_addr_out = s_reg.awaddr;
   assign wr_data_out = s_reg.wdata;
   assign wr_strb_out = s_reg.wstrb;

endmodule : snw_axil_slave
`default_nettype wire

// ===== verification/snw_line_node.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module snw_line_node (
   input wire logic clk_in, // Bus clock.
   input wire logic load_in, // Shift register load pulse.
   input wire logic [8:0] word_in, // Loaded word.
   input wire logic nine_in, // Loaded word has nine bits.
   output logic done_out, // Character received pulse.
   output logic ninth_out // Ninth bit of that character.
);
   logic [9:0] got_q[$];

   // The receiver is idle until the first character arrives.
   initial begin
      done_out = 1'b0;
      ninth_out = 1'b1;
   end

   // Hands over one character; the ninth bit is only valid with the pulse.
   task automatic send_char(input logic n, input int gap);
      repeat (gap) @(posedge clk_in);
      done_out <= 1'b1;
      ninth_out <= n;
      @(posedge clk_in);
      done_out <= 1'b0;
      ninth_out <= ~n;
   endtask : send_char

   // Records every word that the transmitter puts on the line.
   always @(posedge clk_in) begin
      if (load_in === 1'b1) got_q.push_back({nine_in, word_in});
   end
endmodule : snw_line_node
`default_nettype wire

// ===== verification/snw_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module snw_top_tb_top;
   import snw_pkg::*;
   logic clk = 1'b0, nrst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic arv = 1'b0, rry = 1'b0, c9 = 1'b0, lp = 1'b0, src = 1'b0;
   logic dwr = 1'b0, awry, wry, bv, arry, rv, ld, nine, sw, txd_oe_n;
   logic [7:0] awa = 8'h00, ara = 8'h00, dbyte = 8'h00;
   logic [31:0] wd = 32'h0, rd, seed = 32'h6F5A503F, d;
   logic [3:0] ws = 4'h0;
   logic [1:0] br, rr, r;
   logic [8:0] word;
   logic done, ninth, m_rx = 1'b0, m_tx = 1'b0, m_dir = 1'b0;
   int n_errors = 0, cmp_count = 0;

   snw_top dut (.core_clk_in(clk), .nrst_in(nrst_n), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awry), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wry),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arry),
      .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .char9_mode_in(c9), .loop_mode_select_in(lp),
      .receiver_source_select_in(src), .data_wr_in(dwr),
      .data_wr_byte_in(dbyte), .rx_char_done_in(done), .rx_ninth_in(ninth),
      .tx_shift_load_out(ld), .tx_shift_word_out(word),
      .tx_shift_nine_out(nine), .single_wire_out(sw), .txd_oe_n_out(txd_oe_n));
   snw_line_node node (.clk_in(clk), .load_in(ld), .word_in(word),
      .nine_in(nine), .done_out(done), .ninth_out(ninth));

   // Free running 20 MHz clock.
   always #25 clk = ~clk;

   //////////////////////////////////////////////////////////////////////////
   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Counts a comparison and reports a mismatch.
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One bus write; address and data are released as each is taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
         input logic [3:0] s, output logic [1:0] resp);
      bit ad, dd;
      ad = 0;
      dd = 0;
      awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awry === 1'b1) begin ad = 1; awv <= 1'b0; end
         if (wv && wry === 1'b1) begin dd = 1; wv <= 1'b0; end
      end while (!(ad && dd));
      do @(posedge clk); while (bv !== 1'b1);
      resp = br;
      bry <= 1'b0;
      @(posedge clk);
   endtask : axw

   // One bus read; the data is taken at the edge that sees rvalid.
   task automatic axr(input logic [7:0] a, output logic [31:0] v,
         output logic [1:0] resp);
      ara <= a; arv <= 1'b1; rry <= 1'b1;
      do @(posedge clk); while (arry !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      v = rd;
      resp = rr;
      rry <= 1'b0;
      @(posedge clk);
   endtask : axr

   // Reads the control register and compares it with the model.
   task automatic rdchk();
      axr(SNW_CTL3_OFFSET, d, r);
      chk("read resp", 32'(SNW_RESP_OKAY), 32'(r));
      chk("ctl3", {24'h0, m_rx, m_tx, m_dir, 5'h0}, d);
   endtask : rdchk

   // Sets the model fields and writes them out.
   task automatic wr_fields(input logic t, input logic p);
      m_tx = t;
      m_dir = p;
      axw(SNW_CTL3_OFFSET, {24'h0, 1'b0, t, p, 5'h0}, 4'hF, r);
      chk("write resp", 32'(SNW_RESP_OKAY), 32'(r));
   endtask : wr_fields

   // Back to back data writes, then compares every loaded word.
   task automatic burst(input int n);
      logic [9:0] exp_q[$];
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         dwr <= 1'b1;
         dbyte <= seed[7:0];
         exp_q.push_back({c9, c9 & m_tx, seed[7:0]});
         @(posedge clk);
      end
      dwr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("load count", 32'(n), 32'(node.got_q.size()));
      while (exp_q.size() > 0 && node.got_q.size() > 0)
         chk("tx word", 32'(exp_q.pop_front()), 32'(node.got_q.pop_front()));
   endtask : burst

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   //////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk);
      nrst_n <= 1'b1;
      @(posedge clk);
      rdchk();
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr_fields(seed[6], seed[5]);
         axw(SNW_CTL3_OFFSET, ~seed, 4'hE, r); // Byte lane 0 off, no change.
         chk("masked write resp", 32'(SNW_RESP_OKAY), 32'(r));
         rdchk();
      end
      axw(8'h04, 32'hFFFFFFFF, 4'hF, r);
      chk("unmapped write", 32'(SNW_RESP_SLVERR), 32'(r));
      axr(8'h10, d, r);
      chk("unmapped read", 32'(SNW_RESP_SLVERR), 32'(r));
      chk("unmapped data", 32'h0, d);
      rdchk();
      $display("register test done");
      for (int i = 0; i < 4; i++) begin
         c9 <= i[1];
         wr_fields(i[0], m_dir);
         burst(3);
      end
      $display("transmit test done");
      c9 <= 1'b1;
      node.send_char(1'b1, 2);
      m_rx = 1'b1;
      rdchk();
      node.send_char(1'b0, 0);
      m_rx = 1'b0;
      rdchk();
      c9 <= 1'b0;
      node.send_char(1'b1, 1);
      rdchk();
      $display("receive test done");
      for (int i = 0; i < 8; i++) begin
         wr_fields(m_tx, i[0]);
         lp <= i[2];
         src <= i[1];
         repeat (2) @(posedge clk);
         chk("single wire", 32'(i[2] & i[1]), 32'(sw));
         chk("pin oe_n", 32'(i[2] & i[1] & ~i[0]), 32'(txd_oe_n));
      end
      $display("single wire test done");
      // Reset in mid run; the selects drop while reset is held.
      nrst_n <= 1'b0;
      lp <= 1'b0;
      src <= 1'b0;
      repeat (2) @(posedge clk);
      nrst_n <= 1'b1;
      m_tx = 1'b0;
      m_dir = 1'b0;
      repeat (2) @(posedge clk);
      chk("reset single wire", 32'h0, 32'(sw));
      chk("reset oe_n", 32'h0, 32'(txd_oe_n));
      rdchk();
      lp <= 1'b1;
      src <= 1'b1;
      repeat (2) @(posedge clk);
      chk("reset single wire on", 32'h1, 32'(sw));
      chk("reset pin input", 32'h1, 32'(txd_oe_n));
      $display("mid reset test done");
      final_report();
   end

   // Cuts a hang short well beyond the length of the tests.
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule : snw_top_tb_top
`default_nettype wire
